// ### rbl_bist_if.sv
// Link between the control registers and the RAM test engine
// Assumes a single clock domain
`timescale 1ns/100ps
interface rbl_bist_if;
  import rbl_pkg::*;
  logic            start;
  rbl_sel_t        sel;
  logic            done;
  logic            pass;
  logic            fail;
  logic [15:0]     fail_addr;
  logic [12:0]     ram_addr;
  logic [15:0]     ram_wdata;
  logic            ram_we;
  logic [63:0]     ram_rdata;

  modport eng (input start, sel, ram_rdata,
               output done, pass, fail, fail_addr, ram_addr, ram_wdata, ram_we);
  modport ctl (output start, sel, ram_rdata,
               input done, pass, fail, fail_addr, ram_addr, ram_wdata, ram_we);
endinterface : rbl_bist_if

// ### rbl_consts.svh
// Constants for the RAM test / loopback self-test control block
// Assumes inclusion by bare name from every file that uses its macros
`ifndef RBL_CONSTS_SVH
`define RBL_CONSTS_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define RBL_OFS_STC    8'h28
`define RBL_OFS_FAIL   8'h1B
`define RBL_OFS_TXD    8'h1F
`define RBL_OFS_RXD    8'h02
`define RBL_OFS_IST    8'h60
`define RBL_OFS_IMSK   8'h61

// ------------------------------------------------------------
// Control register fields
// ------------------------------------------------------------
`define RBL_B_EN       15
`define RBL_B_SEL_HI   13
`define RBL_B_SEL_LO   11
`define RBL_B_RSTRT    10
`define RBL_B_RPASS    9
`define RBL_B_RFAIL    8
`define RBL_B_ANALOG   5
`define RBL_B_SYNC     4
`define RBL_B_BUSB     3
`define RBL_B_LSTRT    2
`define RBL_B_LPASS    1
`define RBL_B_LFAIL    0
`define RBL_STC_RESET  16'h0000

// ------------------------------------------------------------
// RAM test selections and patterns
// ------------------------------------------------------------
`define RBL_SEL_RDFF   3'b101
`define RBL_SEL_INCDEC 3'b110
`define RBL_SEL_IDLE   3'b111
`define RBL_PAT_ZERO   16'h0000
`define RBL_PAT_ONES   16'hFFFF
`define RBL_QUADS      4
`define RBL_QAW        13

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define RBL_CLK_NS        8
`define RBL_LB_TIMEOUT_NS 100000

`endif

// ### rbl_pkg.sv
// Types for the self-test control block
// Assumes rbl_consts.svh carries the numbers
package rbl_pkg;

  typedef logic [2:0] rbl_sel_t;

  typedef enum logic [2:0] {
    B_IDLE,
    B_WRITE,
    B_RD_ISSUE,
    B_RD_CHECK
  } rbl_bist_st_t;

  typedef enum logic [1:0] {
    L_IDLE,
    L_WAIT
  } rbl_lb_st_t;

endpackage : rbl_pkg

// ### rbl_ram_bist.sv
// RAM test engine: walks one quadrant address, all four quadrants at once
// Assumes a RAM with one-cycle synchronous read, four 16-bit lanes
`timescale 1ns/100ps
`include "rbl_consts.svh"
module rbl_ram_bist import rbl_pkg::*; (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic arst_n,
  // Control side
  rbl_bist_if.eng   b
);

  rbl_bist_st_t    st_ff;
  rbl_sel_t        sel_ff;
  logic            phase_ff;
  logic [12:0]     addr_ff;
  logic [15:0]     exp_ff;
  logic [15:0]     wdata_ff;
  logic            we_ff;
  logic            done_ff;
  logic            pass_ff;
  logic            fail_ff;
  logic [15:0]     fa_ff;
  logic [3:0]      mism;
  logic            last;

  function automatic logic [15:0] pat(rbl_sel_t s, logic ph, logic [12:0] a);
    logic [15:0] v;
    v = (s == `RBL_SEL_INCDEC) ? {3'h0, a} : `RBL_PAT_ZERO;
    return ph ? ~v : v;
  endfunction : pat

  // ------------------------------------------------------------
  // Per-quadrant compare
  // ------------------------------------------------------------
  for (genvar q = 0; q < `RBL_QUADS; q++) begin : g_cmp
    assign mism[q] = b.ram_rdata[q*16 +: 16] != exp_ff;
  end
  assign last = &addr_ff;

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff    <= B_IDLE;
      sel_ff   <= '0;
      phase_ff <= 1'b0;
      addr_ff  <= '0;
      exp_ff   <= '0;
      wdata_ff <= '0;
      we_ff    <= 1'b0;
      done_ff  <= 1'b0;
      pass_ff  <= 1'b0;
      fail_ff  <= 1'b0;
      fa_ff    <= '0;
    end else begin
      done_ff <= 1'b0;
      we_ff   <= 1'b0;
      unique case (st_ff)
        B_IDLE: if (b.start) begin
          sel_ff   <= b.sel;
          addr_ff  <= '0;
          phase_ff <= (b.sel == `RBL_SEL_RDFF);
          pass_ff  <= 1'b0;
          fail_ff  <= 1'b0;
          if (b.sel == `RBL_SEL_IDLE) begin
            done_ff <= 1'b1;
          end else if (b.sel == `RBL_SEL_RDFF) begin
            st_ff <= B_RD_ISSUE;
          end else begin
            st_ff    <= B_WRITE;
            we_ff    <= 1'b1;
            wdata_ff <= pat(b.sel, 1'b0, 13'h0000);
          end
        end
        B_WRITE: begin
          if (last) begin
            st_ff   <= B_RD_ISSUE;
            addr_ff <= '0;
          end else begin
            addr_ff  <= addr_ff + 13'h0001;
            we_ff    <= 1'b1;
            wdata_ff <= pat(sel_ff, phase_ff, addr_ff + 13'h0001);
          end
        end
        B_RD_ISSUE: begin
          st_ff  <= B_RD_CHECK;
          exp_ff <= pat(sel_ff, phase_ff, addr_ff);
        end
        B_RD_CHECK: begin
          if (|mism) begin
            fail_ff <= 1'b1;
            fa_ff   <= {3'h0, addr_ff};
            done_ff <= 1'b1;
            st_ff   <= B_IDLE;
          end else if (last && !phase_ff) begin
            phase_ff <= 1'b1;
            addr_ff  <= '0;
            st_ff    <= B_WRITE;
            we_ff    <= 1'b1;
            wdata_ff <= pat(sel_ff, 1'b1, 13'h0000);
          end else if (last) begin
            pass_ff <= 1'b1;
            done_ff <= 1'b1;
            st_ff   <= B_IDLE;
          end else begin
            addr_ff <= addr_ff + 13'h0001;
            st_ff   <= B_RD_ISSUE;
          end
        end
      endcase
    end
  end

  assign b.done      = done_ff;
  assign b.pass      = pass_ff;
  assign b.fail      = fail_ff;
  assign b.fail_addr = fa_ff;
  assign b.ram_addr  = addr_ff;
  assign b.ram_wdata = wdata_ff;
  assign b.ram_we    = we_ff;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_fail_addr_low: assert property (@(posedge mclk) disable iff (!arst_n)
    st_ff == B_RD_CHECK && |mism |=> done_ff && fail_ff && fa_ff == {3'h0, $past(addr_ff)})
    else $error("fail address not the lowest-quadrant address");
  a_one_result: assert property (@(posedge mclk) disable iff (!arst_n)
    done_ff |-> !(pass_ff && fail_ff))
    else $error("engine reported pass and fail together");

endmodule : rbl_ram_bist

// ### rbl_top.sv
// Self-test control: RAM test results, loopback options, interrupt
// Assumes a single 125 MHz clock and a one-cycle register port
`timescale 1ns/100ps
`include "rbl_consts.svh"
module rbl_top import rbl_pkg::*; #(
  parameter int unsigned LB_TIMEOUT_CYC = `RBL_LB_TIMEOUT_NS / `RBL_CLK_NS
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        arst_n,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // Device pins and normal-mode words
  input  wire logic        test_mode,
  input  wire logic [15:0] rt_msg_info,
  input  wire logic [15:0] rt_cur_cmd,
  // RAM test port
  output logic      [12:0] ram_addr,
  output logic      [15:0] ram_wdata,
  output logic             ram_we,
  input  wire logic [63:0] ram_rdata,
  // Loopback transmit side
  output logic             lb_send,
  output logic      [15:0] lb_word,
  output logic             lb_cmd_sync,
  output logic             lb_analog,
  output logic             lb_bus_b,
  output logic             bus_a_tx_en,
  output logic             bus_b_tx_en,
  // Loopback receive side
  input  wire logic        lb_rx_valid,
  input  wire logic [15:0] lb_rx_word,
  input  wire logic        lb_rx_cmd_sync,
  input  wire logic        lb_rx_err,
  // Interrupt
  output logic             irq
);

  localparam logic [31:0] TO_LAST = LB_TIMEOUT_CYC - 1;

  rbl_bist_if b ();

  logic            en_ff;
  rbl_sel_t        sel_ff;
  logic            rstrt_ff;
  logic            rpass_ff;
  logic            rfail_ff;
  logic            analog_ff;
  logic            sync_ff;
  logic            busb_ff;
  logic            lstrt_ff;
  logic            lpass_ff;
  logic            lfail_ff;
  logic [15:0]     txd_ff;
  logic [15:0]     rxd_ff;
  logic [3:0]      ist_ff;
  logic [3:0]      imsk_ff;
  logic            irq_ff;
  logic [15:0]     rdata_ff;
  logic            start_ff;
  rbl_lb_st_t      lst_ff;
  logic [31:0]     lcnt_ff;
  logic            ldone_ff;
  logic            lok_ff;
  logic            send_ff;
  logic [15:0]     word_ff;
  logic            csync_ff;
  logic            lana_ff;
  logic            lbusb_ff;
  logic            txa_ff;
  logic            txb_ff;
  logic            wr_stc;
  logic            rb_go;
  logic            lb_go;
  logic [15:0]     nxt_rdata;
  logic [3:0]      nxt_ist;

  // ------------------------------------------------------------
  // Write decode and launch gating
  // ------------------------------------------------------------
  assign wr_stc = reg_wr && reg_addr == `RBL_OFS_STC;
  assign rb_go  = wr_stc && reg_wdata[`RBL_B_RSTRT] && test_mode && en_ff && !rstrt_ff;
  assign lb_go  = wr_stc && reg_wdata[`RBL_B_LSTRT] && test_mode && !lstrt_ff;

  // ------------------------------------------------------------
  // Configuration bits
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      en_ff     <= 1'b0;
      sel_ff    <= '0;
      analog_ff <= 1'b0;
      sync_ff   <= 1'b0;
      busb_ff   <= 1'b0;
    end else if (wr_stc) begin
      en_ff     <= reg_wdata[`RBL_B_EN];
      sel_ff    <= reg_wdata[`RBL_B_SEL_HI:`RBL_B_SEL_LO];
      analog_ff <= reg_wdata[`RBL_B_ANALOG];
      sync_ff   <= reg_wdata[`RBL_B_SYNC];
      busb_ff   <= reg_wdata[`RBL_B_BUSB];
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      txd_ff <= '0;
    end else if (reg_wr && reg_addr == `RBL_OFS_TXD) begin
      txd_ff <= reg_wdata;
    end
  end

  // ------------------------------------------------------------
  // RAM test launch and results
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rstrt_ff <= 1'b0;
      start_ff <= 1'b0;
    end else begin
      start_ff <= rb_go;
      if (rb_go) begin
        rstrt_ff <= 1'b1;
      end else if (b.done) begin
        rstrt_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rpass_ff <= 1'b0;
      rfail_ff <= 1'b0;
    end else if (rb_go) begin
      rpass_ff <= 1'b0;
      rfail_ff <= 1'b0;
    end else if (b.done) begin
      rpass_ff <= b.pass && !b.fail;
      rfail_ff <= b.fail;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      b.sel <= '0;
    end else if (rb_go) begin
      b.sel <= reg_wdata[`RBL_B_SEL_HI:`RBL_B_SEL_LO];
    end
  end

  assign b.start     = start_ff;
  assign b.ram_rdata = ram_rdata;
  assign ram_addr    = b.ram_addr;
  assign ram_wdata   = b.ram_wdata;
  assign ram_we      = b.ram_we;

  rbl_ram_bist u_bist (
    .mclk   (mclk),
    .arst_n (arst_n),
    .b      (b)
  );

  // ------------------------------------------------------------
  // Loopback sequencer
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      lst_ff   <= L_IDLE;
      lcnt_ff  <= '0;
      ldone_ff <= 1'b0;
      lok_ff   <= 1'b0;
      send_ff  <= 1'b0;
      word_ff  <= '0;
      csync_ff <= 1'b0;
      lana_ff  <= 1'b0;
      lbusb_ff <= 1'b0;
      txa_ff   <= 1'b0;
      txb_ff   <= 1'b0;
    end else begin
      send_ff  <= 1'b0;
      ldone_ff <= 1'b0;
      unique case (lst_ff)
        L_IDLE: if (lb_go) begin
          lst_ff   <= L_WAIT;
          lcnt_ff  <= '0;
          send_ff  <= 1'b1;
          word_ff  <= txd_ff;
          csync_ff <= reg_wdata[`RBL_B_SYNC];
          lana_ff  <= reg_wdata[`RBL_B_ANALOG];
          lbusb_ff <= reg_wdata[`RBL_B_BUSB];
          txa_ff   <= reg_wdata[`RBL_B_ANALOG] && !reg_wdata[`RBL_B_BUSB];
          txb_ff   <= reg_wdata[`RBL_B_ANALOG] && reg_wdata[`RBL_B_BUSB];
        end
        L_WAIT: begin
          lcnt_ff <= lcnt_ff + 32'h0000_0001;
          if (lb_rx_valid || lcnt_ff == TO_LAST) begin
            lst_ff   <= L_IDLE;
            ldone_ff <= 1'b1;
            lok_ff   <= lb_rx_valid && !lb_rx_err && lb_rx_word == word_ff
                        && lb_rx_cmd_sync == csync_ff;
            txa_ff   <= 1'b0;
            txb_ff   <= 1'b0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      lstrt_ff <= 1'b0;
      lpass_ff <= 1'b0;
      lfail_ff <= 1'b0;
    end else if (lb_go) begin
      lstrt_ff <= 1'b1;
      lpass_ff <= 1'b0;
      lfail_ff <= 1'b0;
    end else if (ldone_ff) begin
      lstrt_ff <= 1'b0;
      lpass_ff <= lok_ff;
      lfail_ff <= !lok_ff;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rxd_ff <= '0;
    end else if (lb_rx_valid && lst_ff == L_WAIT) begin
      rxd_ff <= lb_rx_word;
    end
  end

  assign lb_send     = send_ff;
  assign lb_word     = word_ff;
  assign lb_cmd_sync = csync_ff;
  assign lb_analog   = lana_ff;
  assign lb_bus_b    = lbusb_ff;
  assign bus_a_tx_en = txa_ff;
  assign bus_b_tx_en = txb_ff;

  // ------------------------------------------------------------
  // Interrupt status and mask
  // ------------------------------------------------------------
  always_comb begin
    nxt_ist = ist_ff;
    if (reg_wr && reg_addr == `RBL_OFS_IST) begin
      nxt_ist = ist_ff & ~reg_wdata[3:0];
    end
    nxt_ist = nxt_ist | {ldone_ff && !lok_ff, ldone_ff && lok_ff,
                         b.done && b.fail, b.done && b.pass && !b.fail};
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ist_ff  <= '0;
      imsk_ff <= '0;
      irq_ff  <= 1'b0;
    end else begin
      ist_ff <= nxt_ist;
      irq_ff <= |(nxt_ist & imsk_ff);
      if (reg_wr && reg_addr == `RBL_OFS_IMSK) begin
        imsk_ff <= reg_wdata[3:0];
      end
    end
  end

  assign irq = irq_ff;

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  always_comb begin
    nxt_rdata = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        `RBL_OFS_STC:  nxt_rdata = {en_ff, 1'b0, sel_ff, rstrt_ff, rpass_ff, rfail_ff,
                                    2'b00, analog_ff, sync_ff, busb_ff,
                                    lstrt_ff, lpass_ff, lfail_ff};
        `RBL_OFS_FAIL: nxt_rdata = test_mode ? b.fail_addr : rt_msg_info;
        `RBL_OFS_TXD:  nxt_rdata = txd_ff;
        `RBL_OFS_RXD:  nxt_rdata = test_mode ? rxd_ff : rt_cur_cmd;
        `RBL_OFS_IST:  nxt_rdata = {12'h000, ist_ff};
        `RBL_OFS_IMSK: nxt_rdata = {12'h000, imsk_ff};
        default:       nxt_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_ram_pass_set: assert property (@(posedge mclk) disable iff (!arst_n)
    b.done && b.pass && !rb_go |=> rpass_ff && !rfail_ff)
    else $error("pass flag not set after clean run");
  a_ram_fail_set: assert property (@(posedge mclk) disable iff (!arst_n)
    b.done && b.fail && !rb_go |=> rfail_ff && !rpass_ff)
    else $error("fail flag not set after mismatch");
  a_launch_clears: assert property (@(posedge mclk) disable iff (!arst_n)
    rb_go |=> rstrt_ff && !rpass_ff && !rfail_ff)
    else $error("launch did not clear result flags");
  a_fail_addr_rd: assert property (@(posedge mclk) disable iff (!arst_n)
    reg_rd && reg_addr == `RBL_OFS_FAIL
    |=> reg_rdata == ($past(test_mode) ? $past(b.fail_addr) : $past(rt_msg_info)))
    else $error("location 0x1B returned wrong word");
  a_unused_zero: assert property (@(posedge mclk) disable iff (!arst_n)
    reg_rd && reg_addr == `RBL_OFS_STC |=> reg_rdata[7:6] == 2'b00)
    else $error("unused bits read non-zero");
  a_digital_quiet: assert property (@(posedge mclk) disable iff (!arst_n)
    lst_ff == L_WAIT && !lana_ff |-> !txa_ff && !txb_ff)
    else $error("digital loopback drove a bus");
  a_analog_bus: assert property (@(posedge mclk) disable iff (!arst_n)
    lb_go && reg_wdata[`RBL_B_ANALOG]
    |=> send_ff && (lbusb_ff ? (txb_ff && !txa_ff) : (txa_ff && !txb_ff)))
    else $error("analog loopback on wrong bus");
  a_sync_type: assert property (@(posedge mclk) disable iff (!arst_n)
    lb_go |=> send_ff && csync_ff == $past(reg_wdata[`RBL_B_SYNC]))
    else $error("loopback sync type wrong");
  a_rb_gate: assert property (@(posedge mclk) disable iff (!arst_n)
    $rose(rstrt_ff) |-> $past(test_mode) && $past(en_ff))
    else $error("RAM launch taken without test pin and enable");
  a_rb_auto_clr: assert property (@(posedge mclk) disable iff (!arst_n)
    b.done |=> !rstrt_ff)
    else $error("RAM launch bit not cleared on completion");
  a_lb_gate: assert property (@(posedge mclk) disable iff (!arst_n)
    $rose(lstrt_ff) |-> $past(test_mode) ##0 lst_ff == L_WAIT)
    else $error("loop launch taken without test pin");
  a_one_flag: assert property (@(posedge mclk) disable iff (!arst_n)
    !(rpass_ff && rfail_ff))
    else $error("RAM result flags both set");
  a_flags_stable: assert property (@(posedge mclk) disable iff (!arst_n)
    !rstrt_ff && !rb_go |=> $stable({rpass_ff, rfail_ff}))
    else $error("RAM result flags changed between runs");

endmodule : rbl_top

// ### rbl_top_tb.sv
// Self-checking bench for the self-test control block
// Assumes rbl_consts.svh and rbl_pkg compiled first; one 125 MHz clock
`timescale 1ns/100ps
`include "rbl_consts.svh"
module rbl_top_tb;
  import rbl_pkg::*;
  // ------------------------------------------------------------
  // Signals and RAM lane model
  // ------------------------------------------------------------
  logic        mclk, arst_n, reg_wr, reg_rd, test_mode, ram_we, irq;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rt_msg_info, rt_cur_cmd, ram_wdata, lb_word, lb_rx_word, v, ctl, word;
  logic [12:0] ram_addr, fault_addr;
  logic [63:0] ram_rdata;
  logic        lb_send, lb_cmd_sync, lb_analog, lb_bus_b, bus_a_tx_en, bus_b_tx_en;
  logic        lb_rx_valid, lb_rx_cmd_sync, lb_rx_err, fault_en;
  int          err_count, n_tests, seed, fault_lane;
  rbl_sel_t    sels [4] = '{3'b101, 3'b101, 3'b110, 3'b111};
  int          res [4]  = '{1, 2, 2, 0};
  logic [15:0] lc [3]   = '{16'h0038, 16'h0000, 16'h0020};
  int          lm [3]   = '{0, 1, 2};

  rbl_top #(.LB_TIMEOUT_CYC(20)) rbl_top_i (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .test_mode(test_mode),
    .rt_msg_info(rt_msg_info), .rt_cur_cmd(rt_cur_cmd), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
    .ram_we(ram_we), .ram_rdata(ram_rdata), .lb_send(lb_send), .lb_word(lb_word), .lb_cmd_sync(lb_cmd_sync),
    .lb_analog(lb_analog), .lb_bus_b(lb_bus_b), .bus_a_tx_en(bus_a_tx_en), .bus_b_tx_en(bus_b_tx_en),
    .lb_rx_valid(lb_rx_valid), .lb_rx_word(lb_rx_word), .lb_rx_cmd_sync(lb_rx_cmd_sync),
    .lb_rx_err(lb_rx_err), .irq(irq));

  // Lanes read all ones, one cell may read zero
  always_ff @(posedge mclk) begin
    ram_rdata <= {64{1'b1}};
    if (fault_en && ram_addr == fault_addr) begin
      ram_rdata[fault_lane*16 +: 16] <= 16'h0000;
    end
  end
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic poll(input logic [15:0] m);
    logic [15:0] d;
    int          i;
    d = m;
    i = 0;
    while ((d & m) != 16'h0000 && i < 20000) begin
      rd(`RBL_OFS_STC, d);
      i++;
    end
    if (i >= 20000) begin
      err_count++;
      give_verdict();
    end
  endtask : poll
  // ------------------------------------------------------------
  // Clock and main sequence
  // ------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  initial begin
    seed = 32'h0000_854b;
    {arst_n, reg_wr, reg_rd, lb_rx_valid, lb_rx_cmd_sync, lb_rx_err, fault_en} = '0;
    {reg_addr, reg_wdata, lb_rx_word, fault_addr} = '0;
    test_mode   = 1'b0;
    fault_lane  = 0;
    rt_msg_info = 16'($random(seed));
    rt_cur_cmd  = 16'($random(seed));
    repeat (5) @(posedge mclk);
    arst_n <= 1'b1;
    rd(`RBL_OFS_STC, v);
    chk(v, `RBL_STC_RESET);
    rd(8'h99, v);
    chk(v, 16'h0000);
    rd(`RBL_OFS_RXD, v);
    chk(v, rt_cur_cmd);
    wr(`RBL_OFS_IMSK, 16'h0004);
    wr(`RBL_OFS_STC, 16'h8004);
    wr(`RBL_OFS_STC, 16'h8404);
    rd(`RBL_OFS_STC, v);
    chk(v, 16'h8000);
    @(posedge mclk);
    test_mode <= 1'b1;
    wr(`RBL_OFS_STC, 16'h00F8);
    wr(`RBL_OFS_STC, 16'h04F8);
    rd(`RBL_OFS_STC, v);
    chk(v, 16'h0038);
    $display("test register access done");
    for (int k = 0; k < 4; k++) begin
      fault_en   = (k == 1);
      fault_addr = 13'($random(seed));
      fault_lane = $random(seed) & 3;
      ctl = {1'b1, 1'b0, sels[k], 11'h000};
      wr(`RBL_OFS_STC, ctl);
      wr(`RBL_OFS_STC, ctl | 16'h0400);
      if (sels[k] != 3'b111) begin
        rd(`RBL_OFS_STC, v);
        chk(v, ctl | 16'h0400);
      end
      poll(16'h0400);
      rd(`RBL_OFS_STC, v);
      chk(v, ctl | (res[k] == 1 ? 16'h0200 : res[k] == 2 ? 16'h0100 : 16'h0000));
      rd(`RBL_OFS_IST, v);
      chk(v, res[k] == 1 ? 16'h0001 : res[k] == 2 ? 16'h0002 : 16'h0000);
      chk(irq, 1'b0);
      wr(`RBL_OFS_IST, 16'h000F);
      if (res[k] == 2) begin
        rd(`RBL_OFS_FAIL, v);
        chk(v, fault_en ? {3'b000, fault_addr} : 16'h0000);
        @(posedge mclk);
        test_mode <= 1'b0;
        rd(`RBL_OFS_FAIL, v);
        chk(v, rt_msg_info);
        @(posedge mclk);
        test_mode <= 1'b1;
      end
      $display("test ram run %0d done", k);
    end
    for (int k = 0; k < 3; k++) begin
      word = 16'($random(seed));
      wr(`RBL_OFS_TXD, word);
      wr(`RBL_OFS_STC, lc[k] | 16'h0004);
      #1;
      chk(lb_send, 1'b1);
      chk(lb_word, word);
      chk(lb_cmd_sync, lc[k][4]);
      chk(lb_analog, lc[k][5]);
      chk(lb_bus_b, lc[k][3]);
      chk(bus_a_tx_en, lc[k][5] & ~lc[k][3]);
      chk(bus_b_tx_en, lc[k][5] & lc[k][3]);
      if (lm[k] != 2) begin
        @(posedge mclk);
        lb_rx_valid    <= 1'b1;
        lb_rx_word     <= word ^ (lm[k] == 1 ? 16'h0001 : 16'h0000);
        lb_rx_cmd_sync <= lc[k][4];
        @(posedge mclk);
        lb_rx_valid    <= 1'b0;
      end
      poll(16'h0004);
      rd(`RBL_OFS_STC, v);
      chk(v, lc[k] | (lm[k] == 0 ? 16'h0002 : 16'h0001));
      chk(irq, lm[k] == 0);
      chk(bus_a_tx_en, 1'b0);
      chk(bus_b_tx_en, 1'b0);
      rd(`RBL_OFS_IST, v);
      chk(v, lm[k] == 0 ? 16'h0004 : 16'h0008);
      wr(`RBL_OFS_IST, 16'h000F);
      rd(`RBL_OFS_IST, v);
      chk(v, 16'h0000);
      chk(irq, 1'b0);
      $display("test loopback run %0d done", k);
    end
    give_verdict();
  end
endmodule : rbl_top_tb
